// *** logic/backfeed_prober.sv ***
// probing port end: backfeed probe, toggle detect, full power, removal
// assumes line level and toggle bit arrive asynchronously from the line
`timescale 1ns/1ps
module backfeed_prober
    import backfeed_pkg::*;
#(
    parameter logic [TIMER_W-1:0] PROBE_CYC     = us_to_cyc(PROBE_INTERVAL_US),
    parameter logic [TIMER_W-1:0] TURN_ON_CYC   = us_to_cyc(BACKFEED_TURN_ON_US),
    parameter logic [TIMER_W-1:0] TOGGLE_CYC    = us_to_cyc(TOGGLE_WAIT_US),
    parameter logic [TIMER_W-1:0] DISCHARGE_CYC = us_to_cyc(DISCHARGE_LIMIT_US),
    parameter logic [TIMER_W-1:0] SRC_OFF_CYC   = us_to_cyc(SOURCE_OFF_WAIT_US),
    parameter logic [TIMER_W-1:0] READY_CYC     = us_to_cyc(SINK_READY_US)
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic enable_i,
    backfeed_link_if.prober link,
    output logic      act_as_sink_o,
    output logic      act_as_source_o,
    output logic      send_src_caps_o,
    output logic      probing_o
);
    typedef enum logic [2:0] {
        ST_PROBE, ST_TURN_ON, ST_WAIT_TOGGLE, ST_FULL_POWER, ST_REMOVE, ST_SINK, ST_SOURCE
    } prober_state_e;

    prober_state_e     state_reg, state_next;
    logic [TIMER_W-1:0] tmr_reg, tmr_next;
    logic [TIMER_W-1:0] off_tmr_reg, off_tmr_next;
    logic              tmr_exp_reg, off_exp_reg;
    logic              tmr_load, off_load;
    logic [TIMER_W-1:0] tmr_val;
    logic [1:0]        line_sync_reg, bit_sync_reg;
    logic              bit_prev_reg;
    logic [7:0]        run_len_reg;
    logic [7:0]        gap_reg;
    logic              detected_reg;
    logic              stopped_reg;

    wire line_up  = line_sync_reg[1];
    wire bit_now  = bit_sync_reg[1];
    wire bit_edge = bit_now ^ bit_prev_reg;
    wire gap_long = (gap_reg >= 8'(TOGGLE_HALF_CYC + 1));

    // line and stream inputs are asynchronous to clk_i
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_sync_reg <= 2'h0;
            bit_sync_reg  <= 2'h0;
            bit_prev_reg  <= 1'b0;
        end else begin
            line_sync_reg <= {line_sync_reg[0], link.line_above_off};
            bit_sync_reg  <= {bit_sync_reg[0], link.toggle_bit};
            bit_prev_reg  <= bit_now;
        end
    end

    // stream detector: counts bit transitions, a long gap breaks the run
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_len_reg  <= 8'h00;
            gap_reg      <= 8'h00;
            detected_reg <= 1'b0;
            stopped_reg  <= 1'b0;
        end else begin
            if (bit_edge) begin
                gap_reg <= 8'h00;
            end else if (gap_reg != 8'hFF) begin
                gap_reg <= gap_reg + 8'h01;
            end
            if (gap_long) begin
                run_len_reg <= 8'h00;
            end else if (bit_edge && run_len_reg != 8'hFF) begin
                run_len_reg <= run_len_reg + 8'h01;
            end
            detected_reg <= (run_len_reg >= 8'(TOGGLE_MIN_BITS));
            stopped_reg  <= (gap_reg >= 8'(IDLE_LIMIT_CYC));
        end
    end

    // shared down-counters, expiry flagged for one cycle
    always_comb begin
        tmr_next = tmr_reg;
        if (tmr_load) begin
            tmr_next = tmr_val;
        end else if (tmr_reg != '0) begin
            tmr_next = tmr_reg - 1'b1;
        end
        off_tmr_next = off_tmr_reg;
        if (off_load) begin
            off_tmr_next = SRC_OFF_CYC;
        end else if (off_tmr_reg != '0) begin
            off_tmr_next = off_tmr_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // probe timer starts loaded, so the first backfeed waits a full interval
            tmr_reg     <= PROBE_CYC;
            off_tmr_reg <= '0;
            tmr_exp_reg <= 1'b0;
            off_exp_reg <= 1'b0;
        end else begin
            tmr_reg     <= tmr_next;
            off_tmr_reg <= off_tmr_next;
            tmr_exp_reg <= !tmr_load && (tmr_reg == TIMER_W'(1));
            off_exp_reg <= !off_load && (off_tmr_reg == TIMER_W'(1));
        end
    end

    always_comb begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_val    = PROBE_CYC;
        off_load   = 1'b0;
        case (state_reg)
            ST_PROBE: begin
                if (!enable_i) begin
                    tmr_load = 1'b1;  // hold probe timer loaded while disabled
                end else if (line_up) begin
                    state_next = ST_SINK;
                end else if (tmr_exp_reg) begin
                    state_next = ST_TURN_ON;
                    tmr_load   = 1'b1;
                    tmr_val    = TURN_ON_CYC;
                end
            end
            ST_TURN_ON: begin
                if (tmr_exp_reg) begin
                    state_next = ST_WAIT_TOGGLE;
                    tmr_load   = 1'b1;
                    tmr_val    = TOGGLE_CYC;
                end
            end
            ST_WAIT_TOGGLE: begin
                if (detected_reg) begin
                    state_next = ST_FULL_POWER;
                    tmr_load   = 1'b1;
                    tmr_val    = READY_CYC;
                end else if (tmr_exp_reg) begin
                    state_next = ST_REMOVE;
                    tmr_load   = 1'b1;
                    tmr_val    = DISCHARGE_CYC;
                    off_load   = 1'b1;
                end
            end
            ST_FULL_POWER: begin
                if (stopped_reg) begin
                    state_next = ST_SOURCE;
                end else if (tmr_exp_reg) begin
                    state_next = ST_REMOVE;
                    tmr_load   = 1'b1;
                    tmr_val    = DISCHARGE_CYC;
                    off_load   = 1'b1;
                end
            end
            ST_REMOVE: begin
                if (off_exp_reg) begin
                    state_next = ST_PROBE;
                    tmr_load   = 1'b1;
                    tmr_val    = PROBE_CYC;
                end
            end
            ST_SINK, ST_SOURCE: begin
                state_next = state_reg;
            end
            default: begin
                state_next = ST_PROBE;
            end
        endcase
    end

    // discharge only while the limit timer still runs
    wire discharging = (state_next == ST_REMOVE) && (tmr_next != '0);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg                <= ST_PROBE;
            link.limited_backfeed_on <= 1'b0;
            link.full_five_volt_on   <= 1'b0;
            link.discharge_on        <= 1'b0;
            act_as_sink_o            <= 1'b0;
            act_as_source_o          <= 1'b0;
            send_src_caps_o          <= 1'b0;
            probing_o                <= 1'b0;
        end else begin
            state_reg                <= state_next;
            link.limited_backfeed_on <= (state_next == ST_TURN_ON) ||
                                        (state_next == ST_WAIT_TOGGLE);
            link.full_five_volt_on   <= (state_next == ST_FULL_POWER) ||
                                        (state_next == ST_SOURCE);
            link.discharge_on        <= discharging;
            act_as_sink_o            <= (state_next == ST_SINK);
            act_as_source_o          <= (state_next == ST_SOURCE);
            // one pulse on entry to source operation
            send_src_caps_o          <= (state_next == ST_SOURCE) && (state_reg != ST_SOURCE);
            probing_o                <= (state_next != ST_SINK) && (state_next != ST_SOURCE);
        end
    end
endmodule

// *** logic/backfeed_pkg.sv ***
// shared constants and the microsecond-to-cycle helper for the dead-battery backfeed sequencer ends
// assumes a single 40 MHz system clock on both ends
package backfeed_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned TIMER_W       = 24;
    // nominal durations in microseconds, open to override by each end's parameters except TOGGLE_STOP_US, which neither end uses
    localparam int unsigned PROBE_INTERVAL_US   = 100;
    localparam int unsigned BACKFEED_TURN_ON_US = 10;
    localparam int unsigned TOGGLE_WAIT_US      = 50;
    localparam int unsigned DISCHARGE_LIMIT_US  = 20;
    localparam int unsigned SOURCE_OFF_WAIT_US  = 40;
    localparam int unsigned SINK_READY_US       = 200;
    localparam int unsigned TOGGLE_START_US     = 10;
    localparam int unsigned FULL_POWER_WAIT_US  = 60;
    localparam int unsigned TOGGLE_STOP_US      = 5;
    localparam int unsigned TOGGLE_MIN_BITS     = 128;
    localparam int unsigned TOGGLE_HALF_CYC     = 4;   // stream bit period in clocks
    localparam int unsigned IDLE_LIMIT_CYC      = 16;  // no edge this long = stream stopped

    // least times round up to whole cycles, never below one
    function automatic logic [TIMER_W-1:0] us_to_cyc(input int unsigned us);
        int unsigned c;
        c = (us * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        if (c == 0) begin
            c = 1;
        end
        return c[TIMER_W-1:0];
    endfunction
endpackage

// *** logic/backfeed_link_if.sv ***
// power-line link between the probing port and the partner port
// the bench ties both ends of this interface together
`timescale 1ns/1ps
interface backfeed_link_if;
    logic limited_backfeed_on;  // probing port drives limited backfeed supply
    logic full_five_volt_on;    // probing port drives full five-volt supply
    logic discharge_on;         // probing port discharges the line
    logic line_above_off;       // line is above bus_off_level, as seen by both ends
    logic toggle_bit;           // toggle stream bit sent by the partner

    modport prober (
        output limited_backfeed_on,
        output full_five_volt_on,
        output discharge_on,
        input  line_above_off,
        input  toggle_bit
    );
    modport partner (
        input  line_above_off,
        output toggle_bit
    );
endinterface

// *** logic/backfeed_partner.sv ***
// partner end: dead-battery port that wants power
// assumes line level arrives asynchronously from the line
`timescale 1ns/1ps
module backfeed_partner
    import backfeed_pkg::*;
#(
    parameter logic [TIMER_W-1:0] START_CYC = us_to_cyc(TOGGLE_START_US),
    parameter logic [TIMER_W-1:0] POWER_CYC = us_to_cyc(FULL_POWER_WAIT_US)
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic want_power_i,
    input  wire logic caps_ready_i,
    input  wire logic src_caps_rx_i,
    backfeed_link_if.partner link,
    output logic      full_power_o,
    output logic      cable_check_o,
    output logic      act_as_sink_o
);
    typedef enum logic [2:0] {
        PS_IDLE, PS_SETTLE, PS_STREAM, PS_WAIT_CAPS, PS_SINK
    } partner_state_e;

    partner_state_e     state_reg, state_next;
    logic [TIMER_W-1:0] tmr_reg, tmr_next;
    logic               tmr_exp_reg;
    logic               tmr_load;
    logic [TIMER_W-1:0] tmr_val;
    logic [1:0]         line_sync_reg;
    logic [1:0]         half_reg;
    logic               bit_reg;

    wire line_up = line_sync_reg[1];
    wire streaming = (state_reg == PS_SETTLE) || (state_reg == PS_STREAM);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_sync_reg <= 2'h0;
        end else begin
            line_sync_reg <= {line_sync_reg[0], link.line_above_off};
        end
    end

    // down-counter with one-cycle expiry
    always_comb begin
        tmr_next = tmr_reg;
        if (tmr_load) begin
            tmr_next = tmr_val;
        end else if (tmr_reg != '0) begin
            tmr_next = tmr_reg - 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_val    = POWER_CYC;
        if (!line_up) begin
            state_next = PS_IDLE;
        end else begin
            case (state_reg)
                PS_IDLE: begin
                    if (want_power_i) begin
                        // stream starts at once, well inside the start budget
                        state_next = PS_STREAM;
                        tmr_load   = 1'b1;
                        tmr_val    = POWER_CYC;
                    end
                end
                PS_SETTLE: begin
                    state_next = PS_STREAM;
                end
                PS_STREAM: begin
                    if (tmr_exp_reg) begin
                        state_next = PS_WAIT_CAPS;
                    end
                end
                PS_WAIT_CAPS: begin
                    if (src_caps_rx_i) begin
                        state_next = PS_SINK;
                    end
                end
                PS_SINK: begin
                    state_next = PS_SINK;
                end
                default: begin
                    state_next = PS_IDLE;
                end
            endcase
        end
    end

    // start-time budget kept only as a documented bound here
    wire unused_start = (START_CYC == '0);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg     <= PS_IDLE;
            tmr_reg       <= '0;
            tmr_exp_reg   <= 1'b0;
            half_reg      <= 2'h0;
            bit_reg       <= 1'b0;
            link.toggle_bit <= 1'b0;
            full_power_o  <= 1'b0;
            cable_check_o <= 1'b0;
            act_as_sink_o <= 1'b0;
        end else begin
            state_reg   <= state_next;
            tmr_reg     <= tmr_next;
            tmr_exp_reg <= !tmr_load && (tmr_reg == TIMER_W'(1)) && !unused_start;
            // alternating bits while streaming; holds stream until caps logic ready
            if (streaming || (state_reg == PS_WAIT_CAPS && !caps_ready_i)) begin
                if (half_reg == 2'(TOGGLE_HALF_CYC - 1)) begin
                    half_reg <= 2'h0;
                    bit_reg  <= !bit_reg;
                end else begin
                    half_reg <= half_reg + 2'h1;
                end
            end else if (bit_reg && half_reg != 2'(TOGGLE_HALF_CYC - 1)) begin
                // a one bit runs its full length, so the last stream bit is never cut short
                half_reg <= half_reg + 2'h1;
            end else begin
                half_reg <= 2'h0;
                bit_reg  <= 1'b0;
            end
            link.toggle_bit <= bit_reg && line_up;
            full_power_o  <= (state_next == PS_WAIT_CAPS) || (state_next == PS_SINK);
            cable_check_o <= (state_next == PS_SINK) && (state_reg != PS_SINK);
            act_as_sink_o <= (state_next == PS_SINK);
        end
    end
endmodule

// *** tb/backfeed_checker.sv ***
// concurrent checks on the power-line link between the two sequencer ends
// assumes the bench instantiates it beside the link, clocked by the system clock
`timescale 1ns/1ps
module backfeed_checker #(
    parameter int DISCH_CYC    = 5,
    parameter int BACKFEED_MAX = 812
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic limited_backfeed_on,
    input wire logic full_five_volt_on,
    input wire logic discharge_on,
    input wire logic line_above_off,
    input wire logic toggle_bit
);
    logic [23:0] dis_cnt_reg;
    logic [23:0] bf_cnt_reg;
    logic [23:0] edge_cnt_reg;
    logic        tog_q_reg;

    // edge count is raw line transitions, an upper bound on what the detector saw
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dis_cnt_reg  <= 24'h0;
            bf_cnt_reg   <= 24'h0;
            edge_cnt_reg <= 24'h0;
            tog_q_reg    <= 1'b0;
        end else begin
            dis_cnt_reg  <= discharge_on ? dis_cnt_reg + 24'h1 : 24'h0;
            bf_cnt_reg   <= limited_backfeed_on ? bf_cnt_reg + 24'h1 : 24'h0;
            edge_cnt_reg <= !limited_backfeed_on ? 24'h0
                          : edge_cnt_reg + {23'h0, toggle_bit ^ tog_q_reg};
            tog_q_reg    <= toggle_bit;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_one_supply_mode: assert property (
        $onehot0({limited_backfeed_on, full_five_volt_on, discharge_on}))
        else $error("supplies and discharge overlap");
    a_discharge_length: assert property (
        $fell(discharge_on) |-> dis_cnt_reg == DISCH_CYC)
        else $error("discharge length wrong");
    a_discharge_cap: assert property (
        discharge_on |-> dis_cnt_reg < DISCH_CYC)
        else $error("discharge outlasts limit");
    a_probe_restart: assert property (
        $fell(discharge_on) |-> !limited_backfeed_on [*8] ##[8:40] limited_backfeed_on)
        else $error("probe did not restart in time");
    a_backfeed_from_idle: assert property (
        $rose(limited_backfeed_on) |-> $past(line_above_off) == 1'b0)
        else $error("backfeed applied on a live line");
    a_backfeed_bounded: assert property (
        limited_backfeed_on |-> bf_cnt_reg <= BACKFEED_MAX)
        else $error("backfeed held past toggle wait");
    a_removal_on_timeout: assert property (
        $fell(limited_backfeed_on) && !full_five_volt_on |-> ##[0:2] discharge_on)
        else $error("no removal after toggle wait");
    a_full_after_stream: assert property (
        $rose(full_five_volt_on) |-> $past(limited_backfeed_on) && edge_cnt_reg >= 24'h80)
        else $error("full power without a detected stream");
    a_partner_quiet: assert property (
        (!line_above_off) [*5] |-> !toggle_bit)
        else $error("stream sent on a dead line");
    a_toggle_period: assert property (
        $changed(toggle_bit) |=> ($stable(toggle_bit) || !line_above_off) [*3])
        else $error("stream bit period broken");
endmodule

// *** tb/testbench.sv ***
// self-checking bench: prober and partner joined over one power-line link
// assumes the line level is the OR of the prober's supplies and a bench source
`timescale 1ns/1ps
module testbench;
    import backfeed_pkg::*;
    localparam int P_PROBE = 20;
    localparam int P_ON    = 4;
    localparam int P_WAIT  = 800;
    localparam int P_DIS   = 5;
    localparam int P_OFF   = 10;
    localparam int P_READY = 2000;
    localparam int P_POWER = 50;
    logic clk_i, rst_n_i, enable, want, caps, ext_power, tog_q;
    logic act_src, src_caps, probing, sink, full_pwr, cable, p_sink;
    int   n_fail, total_checks, idle, n;
    backfeed_link_if link();
    assign link.line_above_off = link.limited_backfeed_on | link.full_five_volt_on | ext_power;
    wire [8:0] obs = {full_pwr, link.toggle_bit, p_sink, cable, src_caps, act_src,
                      link.discharge_on, link.full_five_volt_on, link.limited_backfeed_on};

    backfeed_prober #(.PROBE_CYC(TIMER_W'(P_PROBE)), .TURN_ON_CYC(TIMER_W'(P_ON)),
        .TOGGLE_CYC(TIMER_W'(P_WAIT)), .DISCHARGE_CYC(TIMER_W'(P_DIS)),
        .SRC_OFF_CYC(TIMER_W'(P_OFF)), .READY_CYC(TIMER_W'(P_READY))) backfeed_prober_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable), .link(link),
        .act_as_sink_o(sink), .act_as_source_o(act_src), .send_src_caps_o(src_caps),
        .probing_o(probing));
    // capabilities pulse loops straight to the partner, standing in for the message path
    backfeed_partner #(.POWER_CYC(TIMER_W'(P_POWER))) backfeed_partner_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .want_power_i(want), .caps_ready_i(caps),
        .src_caps_rx_i(src_caps), .link(link), .full_power_o(full_pwr),
        .cable_check_o(cable), .act_as_sink_o(p_sink));
    backfeed_checker #(.DISCH_CYC(P_DIS), .BACKFEED_MAX(P_ON + P_WAIT + 8)) backfeed_checker_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .limited_backfeed_on(link.limited_backfeed_on),
        .full_five_volt_on(link.full_five_volt_on), .discharge_on(link.discharge_on),
        .line_above_off(link.line_above_off), .toggle_bit(link.toggle_bit));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // cycles since the stream bit last moved
    always @(posedge clk_i) begin
        idle  <= (link.toggle_bit !== tog_q) ? 0 : idle + 1;
        tog_q <= link.toggle_bit;
    end

    function automatic logic in_win(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction

    function automatic int detect_cyc();
        return int'(TOGGLE_MIN_BITS * TOGGLE_HALF_CYC);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic wait_lvl(input int i, input logic v, input int lim, output int cnt);
        cnt = 0;
        while (obs[i] !== v && cnt < lim) begin
            @(negedge clk_i);
            cnt++;
        end
    endtask

    task automatic do_reset(input logic ext);
        rst_n_i   = 1'b0;
        ext_power = ext;
        repeat (20) @(negedge clk_i);
        rst_n_i = 1'b1;
    endtask

    task automatic done(input string name);
        $display("test %s finished, mismatches so far %0d", name, n_fail);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        rst_n_i = 1'b0; enable = 1'b1; want = 1'b0; caps = 1'b0; ext_power = 1'b0;
        n_fail = 0; total_checks = 0;
        void'($urandom(48));
        // full hand-over, with the partner's readiness arriving at a random moment
        for (int k = 0; k < 3; k++) begin
            want = 1'b1;
            caps = 1'b0;
            do_reset(1'b0);
            wait_lvl(0, 1'b1, P_PROBE + 10, n);
            check(in_win(n, 1, P_PROBE + 4), 1'b1);
            check(probing, 1'b1);
            wait_lvl(7, 1'b1, int'(us_to_cyc(TOGGLE_START_US)), n);
            check(in_win(n, 1, int'(us_to_cyc(TOGGLE_START_US))), 1'b1);
            wait_lvl(1, 1'b1, P_WAIT, n);
            check(in_win(n, detect_cyc() - 8, P_ON + detect_cyc() + 40), 1'b1);
            check(link.limited_backfeed_on, 1'b0);
            wait_lvl(8, 1'b1, 100, n);
            check(full_pwr, 1'b1);
            repeat ($urandom_range(0, 40)) @(negedge clk_i);
            check(link.full_five_volt_on, 1'b1);
            caps = 1'b1;
            wait_lvl(4, 1'b1, 60, n);
            check(in_win(n, 16, 40), 1'b1);
            check(act_src, 1'b1);
            check(idle >= 16, 1'b1);
            @(negedge clk_i);
            check(src_caps, 1'b0);
            wait_lvl(5, 1'b1, 8, n);
            check(cable, 1'b1);
            wait_lvl(6, 1'b1, 8, n);
            check(p_sink, 1'b1);
            check(sink, 1'b0);
            done("handover");
        end
        // nobody answers the probe: timed removal, then a fresh probe
        want = 1'b0;
        do_reset(1'b0);
        wait_lvl(0, 1'b1, P_PROBE + 10, n);
        wait_lvl(0, 1'b0, P_ON + P_WAIT + 20, n);
        check(in_win(n, P_ON + P_WAIT - 2, P_ON + P_WAIT + 6), 1'b1);
        check(link.full_five_volt_on, 1'b0);
        wait_lvl(2, 1'b1, 4, n);
        wait_lvl(2, 1'b0, P_DIS + 4, n);
        check(n, P_DIS);
        wait_lvl(0, 1'b1, P_OFF + P_PROBE + 20, n);
        check(in_win(n + P_DIS, P_OFF + P_PROBE - 2, P_OFF + P_PROBE + 6), 1'b1);
        done("no_answer");
        // partner never becomes ready: sink-ready expiry pulls the line down
        want = 1'b1;
        caps = 1'b0;
        do_reset(1'b0);
        wait_lvl(1, 1'b1, P_PROBE + P_ON + P_WAIT, n);
        wait_lvl(2, 1'b1, P_READY + 20, n);
        check(in_win(n, P_READY - 4, P_READY + 4), 1'b1);
        repeat (4) @(negedge clk_i);
        check(link.toggle_bit, 1'b0);
        wait_lvl(0, 1'b1, P_OFF + P_PROBE + 20, n);
        check(link.limited_backfeed_on, 1'b1);
        done("not_ready");
        // line already powered by someone else
        want = 1'b0;
        do_reset(1'b1);
        repeat (40) @(negedge clk_i);
        check(sink, 1'b1);
        check(link.limited_backfeed_on, 1'b0);
        ext_power = 1'b0;
        repeat (40) @(negedge clk_i);
        check(sink, 1'b1);
        done("live_line");
        // probing switched off: line stays untouched
        enable = 1'b0;
        do_reset(1'b0);
        repeat (60) @(negedge clk_i);
        check(link.limited_backfeed_on, 1'b0);
        check(probing, 1'b1);
        done("disabled");
        tally_and_finish();
    end
endmodule
